// file: phy_basic_control_map.svh
`ifndef PHY_BASIC_CONTROL_MAP_SVH
`define PHY_BASIC_CONTROL_MAP_SVH

// Register offsets on the management port.
`define PBC_ADDR_W          5
`define PBC_OFF_CTRL        5'h00
`define PBC_OFF_ADV_BASE    5'h04
`define PBC_OFF_ADV_1000    5'h09
`define PBC_OFF_COPPER_CTRL 5'h10
`define PBC_OFF_MAC_CTRL1   5'h12
`define PBC_OFF_STATUS      5'h13
`define PBC_OFF_MAC_CTRL2   5'h15

// Field positions in the basic control register.
`define PBC_BIT_RESET       15
`define PBC_BIT_LOOPBACK    14
`define PBC_BIT_SPEED_LSB   13
`define PBC_BIT_AN_ENABLE   12
`define PBC_BIT_POWER_DOWN  11
`define PBC_BIT_ISOLATE     10
`define PBC_BIT_AN_RESTART  9
`define PBC_BIT_DUPLEX      8
`define PBC_BIT_SPEED_MSB   6

// Field positions in the auxiliary registers.
`define PBC_BIT_COPPER_PD   2
`define PBC_BIT_MAC_KEEP    3
`define PBC_ADV_BASE_MSB    8
`define PBC_ADV_BASE_LSB    5
`define PBC_ADV_1000_MSB    9
`define PBC_ADV_1000_LSB    8

// Reset values of the update fields.
`define PBC_RST_SPEED_LSB   1'h0
`define PBC_RST_SPEED_MSB   1'h1
`define PBC_RST_AN_ENABLE   1'h1
`define PBC_RST_DUPLEX      1'h1

// Software reset duration: time in ns and its cycle count at 100 MHz, rounded up.
`define PBC_CLK_MHZ         100
`define PBC_SWRST_TIME_NS   100
`define PBC_SWRST_CYCLES    ((`PBC_SWRST_TIME_NS * `PBC_CLK_MHZ + 999) / 1000)

`endif

// file: phy_basic_control_pkg.sv
package phy_basic_control_pkg;

    // Sequencer for the self-clearing software reset; Gray codes from ST_IDLE to ST_APPLY, but the return to ST_IDLE flips both bits.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_RESET = 2'h1,
        ST_APPLY = 2'h3
    } swrst_state_e;

    // Two-bit speed code, high bit first.
    typedef enum logic [1:0] {
        SPEED_10   = 2'h0,
        SPEED_100  = 2'h1,
        SPEED_1000 = 2'h2,
        SPEED_RSVD = 2'h3
    } speed_e;

    typedef logic [15:0] reg16_t;

endpackage : phy_basic_control_pkg

// file: phy_basic_control_register.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "phy_basic_control_map.svh"

module phy_basic_control_register
    import phy_basic_control_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    // Management register port
    input  wire logic [`PBC_ADDR_W-1:0] reg_addr_in,
    input  wire logic [15:0]            reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [15:0]            reg_rdata_out,
    // Power-down pin, asynchronous to clk_in
    input  wire logic                   power_down_input_pin_in,
    // Data path steering
    output logic                        loopback_out,
    output logic                        link_enable_out,
    output logic                        rate_from_loopback_out,
    output logic      [2:0]             loopback_speed_out,
    output logic      [1:0]             active_speed_out,
    output logic                        active_duplex_out,
    // Negotiation control
    output logic                        an_enable_out,
    output logic                        an_restart_out,
    output logic      [3:0]             adv_base_out,
    output logic      [1:0]             adv_1000_out,
    // Reset and power
    output logic                        sm_reset_out,
    output logic                        power_down_out,
    output logic                        gmii_power_down_out
);

    localparam logic [3:0] SWRST_LOAD = 4'(`PBC_SWRST_CYCLES - 1);

    function automatic logic hit(input logic [`PBC_ADDR_W-1:0] a, input logic [`PBC_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // Pending (written) update fields and other stored bits.
    logic                   spd_lsb_r;
    logic                   spd_msb_r;
    logic                   an_en_r;
    logic                   duplex_r;
    logic                   loop_r;
    logic                   pd_r;
    logic                   copper_pd_r;
    logic                   mac_keep_r;
    logic [2:0]             loop_spd_r;
    logic [3:0]             adv_base_r;
    logic [1:0]             adv_1000_r;
    // Effective copies that drive the link.
    logic [1:0]             eff_speed_r;
    logic                   eff_an_r;
    logic                   eff_duplex_r;
    // Pin synchroniser and edge detect.
    logic                   pin_s1_r;
    logic                   pin_s2_r;
    logic                   pin_s3_r;
    // Sequencer.
    swrst_state_e           st_r;
    swrst_state_e           st_nxt;
    logic [3:0]             cnt_r;
    logic [3:0]             cnt_nxt;

    logic                   wr_ctrl;
    logic                   swrst_req;
    logic                   restart_wr;
    logic                   apply_evt;
    logic                   wake;
    logic                   pd_any;
    logic                   forced_1000;
    logic [1:0]             apply_speed;
    logic                   apply_an;
    logic                   apply_duplex;
    reg16_t                 ctrl_view;
    reg16_t                 rd_mux;

    assign wr_ctrl    = reg_wr_in && hit(reg_addr_in, `PBC_OFF_CTRL);
    assign pd_any     = pd_r | copper_pd_r;
    assign wake       = power_down_out && !pd_any;
    assign swrst_req  = (wr_ctrl && reg_wdata_in[`PBC_BIT_RESET]) || wake;
    assign restart_wr = wr_ctrl && reg_wdata_in[`PBC_BIT_AN_RESTART];
    assign apply_evt  = (st_r == ST_APPLY) || restart_wr;

    // A restart written together with new fields applies those fields at once.
    assign apply_speed  = restart_wr ? {reg_wdata_in[`PBC_BIT_SPEED_MSB], reg_wdata_in[`PBC_BIT_SPEED_LSB]}
                                     : {spd_msb_r, spd_lsb_r};
    assign apply_an     = restart_wr ? reg_wdata_in[`PBC_BIT_AN_ENABLE] : an_en_r;
    assign apply_duplex = restart_wr ? reg_wdata_in[`PBC_BIT_DUPLEX] : duplex_r;
    assign forced_1000  = !eff_an_r && (eff_speed_r == SPEED_1000);

    // Software reset sequencer; a new request during reset restarts the count.
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_IDLE: begin
                if (swrst_req) begin
                    st_nxt  = ST_RESET;
                    cnt_nxt = SWRST_LOAD;
                end
            end
            ST_RESET: begin
                if (swrst_req) begin
                    cnt_nxt = SWRST_LOAD;
                end else if (cnt_r == 4'h0) begin
                    st_nxt = ST_APPLY;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_APPLY: begin
                st_nxt = ST_IDLE;
                if (swrst_req) begin
                    st_nxt  = ST_RESET;
                    cnt_nxt = SWRST_LOAD;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r         <= ST_IDLE;
            cnt_r        <= 4'h0;
            sm_reset_out <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            cnt_r        <= cnt_nxt;
            sm_reset_out <= (st_nxt == ST_RESET);
        end
    end

    // Power-down pin synchroniser; not reset so the level is caught during reset.
    always_ff @(posedge clk_in) begin
        pin_s1_r <= power_down_input_pin_in;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
    end

    // Power-down bit: pin level at hardware reset, pin edges win over writes.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pd_r <= pin_s2_r;
        end else if (pin_s2_r && !pin_s3_r) begin
            pd_r <= 1'b1;
        end else if (!pin_s2_r && pin_s3_r) begin
            pd_r <= 1'b0;
        end else if (wr_ctrl) begin
            pd_r <= reg_wdata_in[`PBC_BIT_POWER_DOWN];
        end
    end

    // Loopback clears on both resets; a reset in progress overrides a write.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            loop_r <= 1'b0;
        end else if (st_nxt == ST_RESET) begin
            loop_r <= 1'b0;
        end else if (wr_ctrl) begin
            loop_r <= reg_wdata_in[`PBC_BIT_LOOPBACK];
        end
    end

    // Pending update fields; they retain across software reset.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            spd_lsb_r <= `PBC_RST_SPEED_LSB;
            spd_msb_r <= `PBC_RST_SPEED_MSB;
            an_en_r   <= `PBC_RST_AN_ENABLE;
            duplex_r  <= `PBC_RST_DUPLEX;
        end else if (wr_ctrl) begin
            spd_lsb_r <= reg_wdata_in[`PBC_BIT_SPEED_LSB];
            spd_msb_r <= reg_wdata_in[`PBC_BIT_SPEED_MSB];
            an_en_r   <= reg_wdata_in[`PBC_BIT_AN_ENABLE];
            duplex_r  <= reg_wdata_in[`PBC_BIT_DUPLEX];
        end
    end

    // Effective settings change only on an apply event.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            eff_speed_r  <= {`PBC_RST_SPEED_MSB, `PBC_RST_SPEED_LSB};
            eff_an_r     <= `PBC_RST_AN_ENABLE;
            eff_duplex_r <= `PBC_RST_DUPLEX;
        end else if (apply_evt) begin
            eff_speed_r  <= apply_speed;
            eff_an_r     <= apply_an;
            eff_duplex_r <= apply_duplex;
        end
    end

    // Auxiliary registers.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            copper_pd_r <= 1'b0;
            mac_keep_r  <= 1'b0;
            loop_spd_r  <= 3'h0;
            adv_base_r  <= 4'hF;
            adv_1000_r  <= 2'h3;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, `PBC_OFF_COPPER_CTRL)) begin
                copper_pd_r <= reg_wdata_in[`PBC_BIT_COPPER_PD];
            end else if (hit(reg_addr_in, `PBC_OFF_MAC_CTRL1)) begin
                mac_keep_r <= reg_wdata_in[`PBC_BIT_MAC_KEEP];
            end else if (hit(reg_addr_in, `PBC_OFF_MAC_CTRL2)) begin
                loop_spd_r <= reg_wdata_in[2:0];
            end else if (hit(reg_addr_in, `PBC_OFF_ADV_BASE)) begin
                adv_base_r <= reg_wdata_in[`PBC_ADV_BASE_MSB:`PBC_ADV_BASE_LSB];
            end else if (hit(reg_addr_in, `PBC_OFF_ADV_1000)) begin
                adv_1000_r <= reg_wdata_in[`PBC_ADV_1000_MSB:`PBC_ADV_1000_LSB];
            end
        end
    end

    // Power outputs.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            power_down_out      <= 1'b0;
            gmii_power_down_out <= 1'b0;
        end else begin
            power_down_out      <= pd_any;
            gmii_power_down_out <= pd_any && !mac_keep_r;
        end
    end

    // Data path and negotiation outputs.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            loopback_out           <= 1'b0;
            link_enable_out        <= 1'b0;
            rate_from_loopback_out <= 1'b0;
            loopback_speed_out     <= 3'h0;
            active_speed_out       <= SPEED_1000;
            active_duplex_out      <= `PBC_RST_DUPLEX;
            an_enable_out          <= `PBC_RST_AN_ENABLE;
            an_restart_out         <= 1'b0;
            adv_base_out           <= 4'h0;
            adv_1000_out           <= 2'h0;
        end else begin
            loopback_out           <= loop_r;
            link_enable_out        <= !loop_r && !pd_any;
            rate_from_loopback_out <= loop_r;
            loopback_speed_out     <= loop_spd_r;
            active_speed_out       <= eff_speed_r;
            active_duplex_out      <= eff_duplex_r;
            an_enable_out          <= eff_an_r || forced_1000;
            an_restart_out         <= apply_evt;
            if (forced_1000) begin
                adv_base_out <= 4'h0;
                adv_1000_out <= eff_duplex_r ? 2'h2 : 2'h1;
            end else begin
                adv_base_out <= adv_base_r;
                adv_1000_out <= adv_1000_r;
            end
        end
    end

    // Isolate, collision test and reserved bits read zero; restart always reads zero, as it is taken on the write itself.
    always_comb begin
        ctrl_view                       = 16'h0000;
        ctrl_view[`PBC_BIT_RESET]       = (st_r != ST_IDLE);
        ctrl_view[`PBC_BIT_LOOPBACK]    = loop_r;
        ctrl_view[`PBC_BIT_SPEED_LSB]   = spd_lsb_r;
        ctrl_view[`PBC_BIT_AN_ENABLE]   = an_en_r;
        ctrl_view[`PBC_BIT_POWER_DOWN]  = pd_r;
        ctrl_view[`PBC_BIT_ISOLATE]     = 1'b0;
        ctrl_view[`PBC_BIT_DUPLEX]      = duplex_r;
        ctrl_view[`PBC_BIT_SPEED_MSB]   = spd_msb_r;
    end

    always_comb begin
        rd_mux = 16'h0000;
        if (hit(reg_addr_in, `PBC_OFF_CTRL)) begin
            rd_mux = ctrl_view;
        end else if (hit(reg_addr_in, `PBC_OFF_COPPER_CTRL)) begin
            rd_mux[`PBC_BIT_COPPER_PD] = copper_pd_r;
        end else if (hit(reg_addr_in, `PBC_OFF_MAC_CTRL1)) begin
            rd_mux[`PBC_BIT_MAC_KEEP] = mac_keep_r;
        end else if (hit(reg_addr_in, `PBC_OFF_MAC_CTRL2)) begin
            rd_mux[2:0] = loop_spd_r;
        end else if (hit(reg_addr_in, `PBC_OFF_ADV_BASE)) begin
            rd_mux[`PBC_ADV_BASE_MSB:`PBC_ADV_BASE_LSB] = adv_base_r;
        end else if (hit(reg_addr_in, `PBC_OFF_ADV_1000)) begin
            rd_mux[`PBC_ADV_1000_MSB:`PBC_ADV_1000_LSB] = adv_1000_r;
        end else if (hit(reg_addr_in, `PBC_OFF_STATUS)) begin
            rd_mux = {10'h000, pd_any, eff_duplex_r, eff_an_r, eff_speed_r, sm_reset_out};
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
        end
    end

    sequence s_quiet_reset;
        (!swrst_req)[*8] ##1 (!swrst_req)[*2];
    endsequence

    sequence s_ctrl_write_plain;
        wr_ctrl && !reg_wdata_in[`PBC_BIT_RESET] && !reg_wdata_in[`PBC_BIT_AN_RESTART] && st_r == ST_IDLE && !wake;
    endsequence

    AST_SWRST_IMMEDIATE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_ctrl && reg_wdata_in[`PBC_BIT_RESET]) |=> sm_reset_out)
        else $error("Software reset did not start on the next cycle.");

    AST_SWRST_SELF_CLEAR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ($rose(sm_reset_out) ##0 s_quiet_reset) |=> (!sm_reset_out && st_r == ST_APPLY))
        else $error("Software reset did not clear after its duration.");

    AST_LOOP_PATH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        loop_r |=> loopback_out)
        else $error("Loopback bit set but data path not looped.");

    AST_LOOP_LINK_DOWN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        loopback_out |-> !link_enable_out)
        else $error("Link enabled while loopback active.");

    AST_LOOP_RATE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        loopback_out |-> (rate_from_loopback_out && loopback_speed_out == $past(loop_spd_r)))
        else $error("Loopback rate not taken from loopback speed field.");

    AST_SPEED_PENDING: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_ctrl_write_plain |=> ##1 $stable(active_speed_out) && $stable(an_enable_out))
        else $error("Speed or negotiation changed without a trigger.");

    AST_FORCED_1000_AN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        forced_1000 |=> (an_enable_out && adv_1000_out == ($past(eff_duplex_r) ? 2'h2 : 2'h1)))
        else $error("Forced 1000 mode did not advertise the duplex mode alone.");

    AST_FORCED_1000_ADV: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        forced_1000 |=> (adv_base_out == 4'h0))
        else $error("Forced 1000 mode leaked base advertisement.");

    AST_AN_RESET_VALUE: assert property (@(posedge clk_in)
        $fell(sys_rst_in) |-> (an_enable_out && an_en_r))
        else $error("Negotiation enable not one after hardware reset.");

    AST_PD_COMBINE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !$past(pd_any) |-> !power_down_out)
        else $error("Powered down with both power-down bits zero.");

    AST_WAKE_RESET: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(power_down_out) |-> (sm_reset_out ##[1:12] an_restart_out))
        else $error("Leaving power down did not reset and restart negotiation.");

    AST_GMII_DOWN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        gmii_power_down_out |-> (power_down_out && !$past(mac_keep_r)))
        else $error("GMII shut down while kept active or powered up.");

    AST_PIN_FALL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!pin_s2_r && pin_s3_r) |=> !pd_r)
        else $error("Pin falling edge did not clear power-down bit.");

    AST_PIN_RISE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pin_s2_r && !pin_s3_r) |=> pd_r)
        else $error("Pin rising edge did not set power-down bit.");

    AST_ISOLATE_ZERO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $past(reg_rd_in) |-> !reg_rdata_out[`PBC_BIT_ISOLATE])
        else $error("Isolate bit read as one.");

    AST_LOOP_CLEAR_SWRST: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sm_reset_out |-> !loop_r)
        else $error("Loopback survived software reset.");

endmodule : phy_basic_control_register

// file: mgmt_master.sv
`timescale 1ns/1ps
`include "phy_basic_control_map.svh"

// Management controller model: one-cycle strobes, read data taken in the cycle after the strobe.
module mgmt_master (
    // Clock
    input  wire logic                   clk_in,
    // Register port
    output logic      [`PBC_ADDR_W-1:0] addr_out,
    output logic      [15:0]            wdata_out,
    output logic                        wr_out,
    output logic                        rd_out,
    input  wire logic [15:0]            rdata_in
);
    initial begin
        addr_out  = 5'h1F;
        wdata_out = 16'h0000;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
    end

    // Each task first lets an edge pass, so two calls never touch a strobe in one time step.
    task automatic wr_reg(input logic [`PBC_ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out    <= 1'b0;
        // Released lines show the inverse so a stale value can never pass for a live one.
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [`PBC_ADDR_W-1:0] a, output logic [15:0] q);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out   <= 1'b0;
        addr_out <= ~a;
        @(negedge clk_in);
        q = rdata_in;
    endtask : rd_reg

    // A disruptive setting is applied by a software reset or a restart; this task writes it together with the reset bit.
    task automatic soft_reset(input logic [15:0] d);
        wr_reg(`PBC_OFF_CTRL, d | 16'h8000);
    endtask : soft_reset
endmodule : mgmt_master

// file: phy_basic_control_register_bench.sv
`timescale 1ns/1ps
`include "phy_basic_control_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t got %h want %h", $time, a, b); end end

module phy_basic_control_register_bench;
    import phy_basic_control_pkg::*;
    logic                   clk_in = 1'b0;
    logic                   sys_rst_in = 1'b1;
    logic                   pin = 1'b0;
    logic [`PBC_ADDR_W-1:0] addr;
    logic [15:0]            wdata, rdata, q, w;
    logic                   wr, rd, lb, lnk, rfl, an, anr, smr, pd, gpd, dup;
    logic [2:0]             lsp;
    logic [1:0]             spd, a1000, code, prev;
    logic [3:0]             abase;
    logic [31:0]            seed = 32'd32667;
    int                     n_fail = 0;
    int                     check_count = 0;

    always #5 clk_in = ~clk_in;

    mgmt_master mgmt (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
                      .rdata_in(rdata));

    phy_basic_control_register dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .power_down_input_pin_in(pin), .loopback_out(lb), .link_enable_out(lnk),
        .rate_from_loopback_out(rfl), .loopback_speed_out(lsp), .active_speed_out(spd),
        .active_duplex_out(dup), .an_enable_out(an), .an_restart_out(anr), .adv_base_out(abase),
        .adv_1000_out(a1000), .sm_reset_out(smr), .power_down_out(pd), .gmii_power_down_out(gpd));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] ctrl_word(input logic [1:0] c, input logic e, input logic d);
        return {2'h0, c[0], e, 3'h0, d, 1'b0, c[1], 6'h00};
    endfunction : ctrl_word

    task automatic wait_restart();
        for (int k = 0; k < 40; k++) begin
            @(negedge clk_in);
            if (anr === 1'b1) break;
        end
        `CHK(anr, 1'b1);
        // Effective settings reach the outputs one cycle after the restart pulse.
        @(negedge clk_in);
    endtask : wait_restart

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        finish_test();
    end

    initial begin
        logic e, d;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        mgmt.rd_reg(`PBC_OFF_CTRL, q);
        `CHK(q, 16'h1140);
        `CHK({an, spd, dup, lb}, 5'b11010);
        prev = 2'h2;
        // Speed codes 10, 100 and 1000 (not SPEED_RSVD), each applied both by software reset and by a restart write.
        for (int i = 0; i < 6; i++) begin
            code = 2'(i % 3);
            e = 1'(rnd());
            d = 1'(rnd());
            w = ctrl_word(code, e, d);
            mgmt.wr_reg(`PBC_OFF_CTRL, w);
            @(negedge clk_in);
            `CHK(spd, prev);
            if (i >= 3) begin
                mgmt.soft_reset(w);
                @(negedge clk_in);
                `CHK(smr, 1'b1);
                mgmt.rd_reg(`PBC_OFF_CTRL, q);
                `CHK(q[15], 1'b1);
            end else begin
                mgmt.wr_reg(`PBC_OFF_CTRL, w | 16'h0200);
            end
            wait_restart();
            `CHK({spd, dup}, {code, d});
            `CHK(an, e | (code == 2'h2));
            `CHK(a1000, (code == 2'h2 && !e) ? (d ? 2'h2 : 2'h1) : 2'h3);
            `CHK(abase, (code == 2'h2 && !e) ? 4'h0 : 4'hF);
            mgmt.rd_reg(`PBC_OFF_CTRL, q);
            `CHK(q, w);
            prev = code;
        end
        // Loopback with isolate written: isolate must read back zero.
        lsp_w: begin
            logic [2:0] s;
            s = 3'(rnd());
            mgmt.wr_reg(`PBC_OFF_MAC_CTRL2, {13'h0000, s});
            mgmt.wr_reg(`PBC_OFF_CTRL, w | 16'h4400);
            repeat (2) @(negedge clk_in);
            `CHK({lb, lnk, rfl}, 3'b101);
            `CHK(lsp, s);
        end
        mgmt.rd_reg(`PBC_OFF_CTRL, q);
        `CHK(q, w | 16'h4000);
        mgmt.soft_reset(w | 16'h4000);
        wait_restart();
        `CHK({lb, lnk}, 2'b01);
        // Pin rise sets the power-down bit; a software reset keeps it.
        @(posedge clk_in) pin <= 1'b1;
        repeat (6) @(negedge clk_in);
        `CHK({pd, gpd, lnk}, 3'b110);
        mgmt.soft_reset(w | 16'h0800);
        wait_restart();
        mgmt.rd_reg(`PBC_OFF_CTRL, q);
        `CHK(q[11], 1'b1);
        mgmt.wr_reg(`PBC_OFF_MAC_CTRL1, 16'h0008);
        repeat (2) @(negedge clk_in);
        `CHK(gpd, 1'b0);
        mgmt.wr_reg(`PBC_OFF_COPPER_CTRL, 16'h0004);
        mgmt.wr_reg(`PBC_OFF_CTRL, ctrl_word(2'h1, 1'b1, 1'b0) | 16'h0800);
        pin <= 1'b0;
        repeat (6) @(negedge clk_in);
        mgmt.rd_reg(`PBC_OFF_CTRL, q);
        `CHK(q[11], 1'b0);
        `CHK({pd, spd}, 3'b110);
        mgmt.wr_reg(`PBC_OFF_COPPER_CTRL, 16'h0000);
        wait_restart();
        `CHK({pd, spd, an}, 4'b0011);
        // Mid-run hardware reset with the pin raised inside it: the bit must load the pin level.
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        pin        <= 1'b1;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        mgmt.rd_reg(`PBC_OFF_CTRL, q);
        `CHK({q, pd, lb}, {16'h1940, 1'b1, 1'b0});
        // Unmapped place: writes vanish and reads return zero.
        mgmt.wr_reg(5'h1F, 16'hFFFF);
        mgmt.rd_reg(5'h1F, q);
        `CHK(q, 16'h0000);
        finish_test();
    end
endmodule : phy_basic_control_register_bench
